/* File: adccs_defs.svh */
`ifndef ADCCS_DEFS_SVH
`define ADCCS_DEFS_SVH
// ********************
// Byte layouts
// ********************
`define ADCCS_MSB 7
`define ADCCS_SCAN_HI 6
`define ADCCS_SCAN_LO 5
`define ADCCS_RB_HI 4
`define ADCCS_RB_LO 3
`define ADCCS_CS_HI 2
`define ADCCS_CS_LO 1
`define ADCCS_SE 0
`define ADCCS_REF_HI 6
`define ADCCS_REF_LO 5
`define ADCCS_REFPU 4
`define ADCCS_CLKSEL 3
`define ADCCS_POL 2
`define ADCCS_RESET_N 1
`define ADCCS_MONSET 0
// ********************
// Reset values and counts
// ********************
`define ADCCS_CFG_RST 8'h01
`define ADCCS_SETUP_RST 8'h82
`define ADCCS_MON_BYTES 4'hD
`define ADCCS_REPEAT_CNT 4'h8
`define ADCCS_LAST_CH 2'h3
`define ADCCS_ACK_SLOT 4'h8
`define ADCCS_BUF_DEPTH 2'h2
`define ADCCS_HS_CODE 5'h01
`define ADCCS_TAG_LEAD 1'b1
`define ADCCS_TAG_12B 1'b1
`define ADCCS_DEV_ADDR 7'h34
// ********************
// Timing
// ********************
`define ADCCS_CLK_HZ 50000000
`define ADCCS_FS_HZ 400000
`define ADCCS_REF_WAKE_MS 10
`define ADCCS_REF_WAKE_CYC (`ADCCS_REF_WAKE_MS * (`ADCCS_CLK_HZ / 1000))
`define ADCCS_SCL_HALF_CYC ((`ADCCS_CLK_HZ + 2 * `ADCCS_FS_HZ - 1) / (2 * `ADCCS_FS_HZ))
`endif

/* File: adccs_pkg.sv */
package adccs_pkg;
  // Scan mode field codes
  typedef enum logic [1:0] {
    ADCCS_SCAN_UP = 2'b00,
    ADCCS_SCAN_REPEAT = 2'b01,
    ADCCS_SCAN_MON = 2'b10,
    ADCCS_SCAN_SINGLE = 2'b11
  } adccs_scan_t;
  // Device bus states
  typedef enum logic [2:0] {
    D_IDLE = 3'b000,
    D_ADDR = 3'b001,
    D_WRITE = 3'b010,
    D_READ = 3'b011,
    D_SKIP = 3'b100
  } adccs_dst_t;
  // Host bus states
  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_START = 3'b001,
    H_LOW = 3'b010,
    H_HIGH = 3'b011,
    H_STOP0 = 3'b100,
    H_STOP1 = 3'b101
  } adccs_hst_t;
  typedef logic [7:0] adccs_byte_t;
  typedef logic [11:0] adccs_result_t;
  typedef logic [1:0] adccs_chan_t;
endpackage : adccs_pkg

/* File: adccs_if.sv */
`timescale 1ns/1ps
interface adccs_if;
  // Host pin drivers
  logic host_scl_o, host_scl_oe, host_sda_o, host_sda_oe;
  // Device pin drivers
  logic dev_scl_o, dev_scl_oe, dev_sda_o, dev_sda_oe;
  // Open-drain lines, pulled high when nobody pulls low
  logic scl, sda;
  assign scl = !(host_scl_oe && !host_scl_o) && !(dev_scl_oe && !dev_scl_o);
  assign sda = !(host_sda_oe && !host_sda_o) && !(dev_sda_oe && !dev_sda_o);
  modport dev (input scl, sda, output dev_scl_o, dev_scl_oe, dev_sda_o, dev_sda_oe);
  modport host (input scl, sda, output host_scl_o, host_scl_oe, host_sda_o, host_sda_oe);
endinterface : adccs_if

/* File: adccs_host.sv */
`timescale 1ns/1ps
`include "adccs_defs.svh"
module adccs_host #(
  parameter int HALF = `ADCCS_SCL_HALF_CYC,
  parameter logic [6:0] DEV_ADDR = `ADCCS_DEV_ADDR
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Two-wire link
  adccs_if.host link,
  // Transfer request
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_read,
  input wire logic [3:0] cmd_count,
  input wire adccs_pkg::adccs_byte_t cmd_config,
  input wire adccs_pkg::adccs_byte_t cmd_setup,
  input wire logic cmd_wr_setup,
  // Received bytes
  output logic rx_valid,
  input wire logic rx_ready,
  output adccs_pkg::adccs_byte_t rx_data,
  // Status
  output logic addr_nack,
  output logic busy
);
  import adccs_pkg::*;

  typedef struct packed {
    logic scl1, scl2, sda1, sda2;
    adccs_hst_t st;
    logic [15:0] div;
    logic [3:0] bitcnt;
    logic [1:0] idx;
    adccs_byte_t sh, cfg, setup;
    logic rd, wsetup, nack, scl_oe, sda_oe;
    logic [3:0] cnt;
    logic [1:0][7:0] rxq;
    logic [1:0] rxn;
  } adccs_host_state_t;

  adccs_host_state_t r, n;
  logic tick, sending, stall, push, pop;
  logic [1:0] rxn_after;

  // ********************
  // Decodes
  // ********************
  assign tick = r.div == 16'(HALF - 1);
  assign sending = (r.idx == 2'h0) || !r.rd;
  assign stall = !sending && r.bitcnt == 4'h0 && r.rxn == `ADCCS_BUF_DEPTH; // Full buffer holds the clock low
  assign push = r.st == H_HIGH && tick && r.scl2 && r.bitcnt == `ADCCS_ACK_SLOT - 4'h1 && !sending;
  assign pop = rx_valid && rx_ready;
  assign rxn_after = r.rxn - {1'b0, pop};

  // Next state of the bus master
  always_comb begin
    n = r;
    n.scl1 = link.scl;
    n.scl2 = r.scl1;
    n.sda1 = link.sda;
    n.sda2 = r.sda1;
    n.div = (tick || r.st == H_IDLE) ? 16'h0 : r.div + 16'h1;
    unique case (r.st)
      H_IDLE: begin
        n.scl_oe = 1'b0;
        n.sda_oe = 1'b0;
        if (cmd_valid) begin
          n.st = H_START;
          n.rd = cmd_read;
          n.cnt = cmd_count;
          n.cfg = cmd_config;
          n.setup = cmd_setup;
          n.wsetup = cmd_wr_setup;
          n.sh = {DEV_ADDR, cmd_read}; // [R10] [R22]
          n.idx = 2'h0;
          n.bitcnt = 4'h0;
          n.nack = 1'b0;
        end
      end
      H_START: if (tick) begin
        if (!r.sda_oe) n.sda_oe = 1'b1;
        else begin
          n.scl_oe = 1'b1;
          n.st = H_LOW;
        end
      end
      H_LOW: begin
        // Data moves only while the clock is low
        if (r.bitcnt != `ADCCS_ACK_SLOT) n.sda_oe = sending && !r.sh[`ADCCS_MSB];
        else n.sda_oe = !sending && r.cnt != 4'h1;
        if (tick && !stall) begin
          n.scl_oe = 1'b0;
          n.st = H_HIGH;
        end
      end
      H_HIGH: begin
        if (!r.scl2) n.div = 16'h0; // Device stretches the clock
        if (tick && r.scl2) begin
          n.scl_oe = 1'b1;
          n.st = H_LOW;
          if (r.bitcnt != `ADCCS_ACK_SLOT) begin
            n.sh = {r.sh[6:0], r.sda2};
            n.bitcnt = r.bitcnt + 4'h1;
          end else begin
            n.bitcnt = 4'h0;
            if (sending && r.sda2) begin
              n.nack = 1'b1;
              n.st = H_STOP0;
            end else if (!r.rd && r.idx == 2'h0) begin
              n.idx = 2'h1;
              n.sh = {1'b0, r.cfg[6:0]}; // [R1] [R12]
            end else if (!r.rd && r.idx == 2'h1 && r.wsetup) begin
              n.idx = 2'h2;
              n.sh = {1'b1, r.setup[6:0]}; // [R11] [R13]
            end else if (r.rd && r.idx == 2'h0 && r.cnt != 4'h0) n.idx = 2'h1;
            else if (r.rd && r.idx != 2'h0 && r.cnt > 4'h1) n.cnt = r.cnt - 4'h1;
            else n.st = H_STOP0; // [R16]
          end
        end
      end
      H_STOP0: begin
        n.sda_oe = 1'b1;
        if (tick) begin
          n.scl_oe = 1'b0;
          n.st = H_STOP1;
        end
      end
      H_STOP1: if (tick && r.scl2) begin
        n.sda_oe = 1'b0;
        n.st = H_IDLE;
      end
      default: n.st = H_IDLE;
    endcase
    // Two-entry receive buffer
    if (pop) n.rxq[0] = r.rxq[1];
    if (push) n.rxq[rxn_after[0]] = {r.sh[6:0], r.sda2};
    n.rxn = rxn_after + {1'b0, push};
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) r <= '0;
    else if (ce) r <= n;
  end

  // Outputs
  assign cmd_ready = r.st == H_IDLE;
  assign rx_valid = r.rxn != 2'h0;
  assign rx_data = r.rxq[0];
  assign addr_nack = r.nack;
  assign busy = r.st != H_IDLE;
  assign link.host_scl_o = 1'b0;
  assign link.host_sda_o = 1'b0;
  assign link.host_scl_oe = r.scl_oe;
  assign link.host_sda_oe = r.sda_oe;
endmodule : adccs_host

/* File: adccs_dev.sv */
`timescale 1ns/1ps
`include "adccs_defs.svh"
// Summary of operation
// R1 - Configuration byte has MSB zero
// R2 - Scan 0,0 converts channel 0 up to limit
// R3 - Scan 0,1 converts one channel eight times
// R4 - Scan 1,0 repeats channel 0 to limit forever
// R5 - Scan 1,1 converts selected channel once
// R6 - Readback bits both one expose monitor setup
// R7 - Channel field is limit or single channel
// R8 - Bit 0 selects single-ended or differential
// R9 - Single-ended forces unipolar conversions
// R10 - Address with write bit zero, then ack
// R11 - Data MSB one is setup, zero config
// R12 - Master writes config before setup
// R13 - Setup reset restores power-up configuration
// R14 - Monitor setup accepts thirteen more bytes
// R15 - STOP leaves high-speed bus mode
// R16 - External clock idles on STOP, NACK, restart
// R17 - Internal clock powers down after last store
// R18 - Matching address powers up conversion circuitry
// R19 - Internal reference needs 10ms after wake
// R20 - Reference on input 3 drops it from scans
// R21 - Results stored and returned in conversion order
// R22 - Read address starts the conversion sequence
// R23 - Setup bit 1 low resets configuration only
// R24 - Setup bit 3 selects conversion clock
module adccs_dev #(
  parameter int REF_WAKE = `ADCCS_REF_WAKE_CYC,
  parameter logic [6:0] DEV_ADDR = `ADCCS_DEV_ADDR
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Two-wire link
  adccs_if.dev link,
  // Conversion request to the analog core
  output logic cmd_valid,
  input wire logic cmd_ready,
  output adccs_pkg::adccs_chan_t cmd_ch,
  output logic cmd_diff,
  output logic cmd_bipolar,
  output logic cmd_ext_clk,
  // Results from the analog core
  input wire logic res_valid,
  output logic res_ready,
  input wire adccs_pkg::adccs_result_t res_data,
  // Status
  output logic powered,
  output logic ref_ready,
  output logic high_speed_bus_mode
);
  import adccs_pkg::*;

  localparam int RW = $clog2(REF_WAKE + 1);

  typedef struct packed {
    logic scl1, scl2, scl3, sda1, sda2, sda3;
    adccs_dst_t st;
    logic [3:0] bitcnt;
    adccs_byte_t sh, cfg, setup;
    logic ack, sda_oe, scl_oe, hilo, rb, hs, pwr;
    logic [3:0] mon_left, mon_wr, len, wr_idx, rd_ptr;
    logic [12:0][7:0] mon;
    logic seq_act, done, cmd_out;
    logic [7:0][13:0] mem;
    logic [RW-1:0] ref_cnt;
    logic [1:0][11:0] fq;
    logic [1:0] fcnt;
    adccs_chan_t cmd_ch;
    logic cmd_diff, cmd_bip, cmd_ext;
  } adccs_dev_state_t;

  adccs_dev_state_t r, n;
  logic rise, fall, start_c, stop_c, ext, need_wake, ref_ok, push, pop;
  logic [1:0] fcnt_after;
  logic [3:0] rd_lim;
  adccs_byte_t byte_in, tx;

  // ********************
  // Scan decoding
  // ********************
  // Number of results in one pass of the current scan
  function automatic logic [3:0] seq_len(input adccs_byte_t c, input adccs_byte_t s);
    logic [1:0] lim;
    lim = c[`ADCCS_CS_HI:`ADCCS_CS_LO];
    if (s[`ADCCS_REF_LO] && lim == `ADCCS_LAST_CH) lim = `ADCCS_LAST_CH - 2'h1; // [R20]
    unique case (adccs_scan_t'(c[`ADCCS_SCAN_HI:`ADCCS_SCAN_LO]))
      ADCCS_SCAN_UP, ADCCS_SCAN_MON: seq_len = {2'h0, lim} + 4'h1; // [R2] [R4]
      ADCCS_SCAN_REPEAT: seq_len = `ADCCS_REPEAT_CNT; // [R3]
      ADCCS_SCAN_SINGLE: seq_len = 4'h1; // [R5]
    endcase
  endfunction : seq_len

  // Channel of the k-th conversion; odd modes stay on one channel
  function automatic adccs_chan_t seq_chan(input adccs_byte_t c, input logic [3:0] k);
    if (c[`ADCCS_SCAN_LO]) seq_chan = c[`ADCCS_CS_HI:`ADCCS_CS_LO]; // [R7]
    else seq_chan = k[1:0];
  endfunction : seq_chan

  // ********************
  // Link event detection
  // ********************
  // Only the second and third sync stages feed detectors
  assign rise = r.scl2 && !r.scl3;
  assign fall = !r.scl2 && r.scl3;
  assign start_c = r.scl2 && r.scl3 && r.sda3 && !r.sda2;
  assign stop_c = r.scl2 && r.scl3 && !r.sda3 && r.sda2;
  assign byte_in = {r.sh[6:0], r.sda2};
  assign ext = r.setup[`ADCCS_CLKSEL]; // [R24]
  assign need_wake = r.setup[`ADCCS_REF_HI] && !r.setup[`ADCCS_REFPU];
  assign ref_ok = !need_wake || r.ref_cnt == RW'(REF_WAKE); // [R19]
  assign rd_lim = r.rb ? `ADCCS_MON_BYTES : r.len;
  // Result frame: lead one, channel tag, 12-bit flag, data
  assign tx = r.rb ? r.mon[r.rd_ptr] :
              r.hilo ? r.mem[r.rd_ptr[2:0]][7:0] :
              {`ADCCS_TAG_LEAD, r.mem[r.rd_ptr[2:0]][13:12], `ADCCS_TAG_12B, r.mem[r.rd_ptr[2:0]][11:8]};
  assign pop = r.fcnt != 2'h0 && r.seq_act && r.cmd_out;
  assign push = res_valid && res_ready;
  assign fcnt_after = r.fcnt - {1'b0, pop};

  // Next state of the whole device
  always_comb begin
    n = r;
    n.scl1 = link.scl;
    n.scl2 = r.scl1;
    n.scl3 = r.scl2;
    n.sda1 = link.sda;
    n.sda2 = r.sda1;
    n.sda3 = r.sda2;
    // Reference wake timer restarts on every power-up
    if (!r.pwr || !need_wake) n.ref_cnt = '0;
    else if (!ref_ok) n.ref_cnt = r.ref_cnt + 1'b1; // [R19]
    if (cmd_valid && cmd_ready) n.cmd_out = 1'b1;
    // Store each result at the slot of its conversion
    if (pop) begin
      n.mem[r.wr_idx[2:0]] = {seq_chan(r.cfg, r.wr_idx), r.fq[0]}; // [R21]
      n.cmd_out = 1'b0;
      if (r.wr_idx + 4'h1 == r.len) begin
        n.wr_idx = 4'h0;
        n.done = 1'b1;
        if (r.cfg[`ADCCS_SCAN_HI:`ADCCS_SCAN_LO] != ADCCS_SCAN_MON) begin // [R4]
          n.seq_act = 1'b0;
          if (!ext) n.pwr = 1'b0; // [R17]
        end
      end else n.wr_idx = r.wr_idx + 4'h1;
    end
    // Two-entry result buffer
    if (pop) n.fq[0] = r.fq[1];
    if (push) n.fq[fcnt_after[0]] = res_data;
    n.fcnt = fcnt_after + {1'b0, push};
    // Bus slave
    if (start_c || stop_c) begin
      if (r.st != D_IDLE && (ext || !r.seq_act)) n.pwr = 1'b0; // [R16]
      if (stop_c) n.hs = 1'b0; // [R15]
      n.st = start_c ? D_ADDR : D_IDLE;
      n.bitcnt = 4'h0;
      n.ack = 1'b0;
      n.sda_oe = 1'b0;
      n.mon_left = 4'h0; // [R14]
    end else if (rise && r.st != D_IDLE) begin
      if (r.bitcnt != `ADCCS_ACK_SLOT) begin
        n.sh = byte_in;
        n.bitcnt = r.bitcnt + 4'h1;
        if (r.bitcnt == `ADCCS_ACK_SLOT - 4'h1) begin
          unique case (r.st)
            D_ADDR: begin
              if (byte_in[7:1] == DEV_ADDR) begin
                n.ack = 1'b1; // [R10]
                n.pwr = 1'b1; // [R18]
                n.st = byte_in[0] ? D_READ : D_WRITE;
                if (byte_in[0]) begin
                  n.seq_act = 1'b1; // [R22]
                  n.done = 1'b0;
                  n.wr_idx = 4'h0;
                  n.cmd_out = 1'b0;
                  n.len = seq_len(r.cfg, r.setup);
                  n.rb = &r.cfg[`ADCCS_RB_HI:`ADCCS_RB_LO]; // [R6]
                  n.rd_ptr = 4'h0;
                  n.hilo = 1'b0;
                end
              end else begin
                // Master code is left unacknowledged
                n.st = D_SKIP;
                if (byte_in[7:3] == `ADCCS_HS_CODE) n.hs = 1'b1;
              end
            end
            D_WRITE: begin
              n.ack = 1'b1;
              if (r.mon_left != 4'h0) begin
                n.mon[r.mon_wr] = byte_in; // [R14]
                n.mon_wr = r.mon_wr + 4'h1;
                n.mon_left = r.mon_left - 4'h1;
              end else if (byte_in[`ADCCS_MSB]) begin
                n.setup = byte_in; // [R11]
                if (!byte_in[`ADCCS_RESET_N]) n.cfg = `ADCCS_CFG_RST; // [R13] [R23]
                if (byte_in[`ADCCS_MONSET]) begin
                  n.mon_left = `ADCCS_MON_BYTES;
                  n.mon_wr = 4'h0;
                end
              end else begin
                n.cfg = byte_in; // [R1] [R11]
                n.seq_act = 1'b0;
              end
            end
            default: ;
          endcase
        end
      end else begin
        n.bitcnt = 4'h0;
        n.ack = 1'b0;
        if (r.st == D_READ && r.sda2) begin
          n.st = D_SKIP;
          if (ext) n.pwr = 1'b0; // [R16]
        end else if (r.st == D_READ && !r.ack) begin
          n.hilo = !r.hilo && !r.rb;
          if (r.rb || r.hilo) n.rd_ptr = (r.rd_ptr + 4'h1 == rd_lim) ? 4'h0 : r.rd_ptr + 4'h1; // [R21]
        end
      end
    end else if (fall) begin
      // Drive only after the clock is low so data never moves under a high clock
      n.sda_oe = 1'b0;
      if (r.ack) begin
        n.sda_oe = 1'b1;
        if (r.st == D_READ && !r.done) n.scl_oe = 1'b1; // Hold clock until results are stored
      end else if (r.st == D_READ && r.bitcnt != `ADCCS_ACK_SLOT) n.sda_oe = !tx[3'h7 - r.bitcnt[2:0]];
    end
    if (r.scl_oe && r.done) n.scl_oe = 1'b0;
    // Request fields follow the next state
    n.cmd_ch = seq_chan(n.cfg, n.wr_idx); // [R2] [R3]
    n.cmd_diff = !n.cfg[`ADCCS_SE]; // [R8]
    n.cmd_bip = n.cfg[`ADCCS_SE] ? 1'b0 : n.setup[`ADCCS_POL]; // [R9]
    n.cmd_ext = n.setup[`ADCCS_CLKSEL]; // [R24]
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r <= '0;
      r.cfg <= `ADCCS_CFG_RST;
      r.setup <= `ADCCS_SETUP_RST;
    end else if (ce) r <= n;
  end

  // ********************
  // Outputs
  // ********************
  assign cmd_valid = r.seq_act && r.pwr && !r.cmd_out && ref_ok; // [R19]
  assign cmd_ch = r.cmd_ch;
  assign cmd_diff = r.cmd_diff;
  assign cmd_bipolar = r.cmd_bip;
  assign cmd_ext_clk = r.cmd_ext;
  assign res_ready = r.fcnt != `ADCCS_BUF_DEPTH;
  assign powered = r.pwr;
  assign ref_ready = r.pwr && ref_ok;
  assign high_speed_bus_mode = r.hs;
  assign link.dev_scl_o = 1'b0;
  assign link.dev_sda_o = 1'b0;
  assign link.dev_scl_oe = r.scl_oe;
  assign link.dev_sda_oe = r.sda_oe;
endmodule : adccs_dev

/* File: adccs_props.sv */
`timescale 1ns/1ps
module adccs_props #(
  parameter logic [6:0] DEV_ADDR = 7'h34
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Pin drivers
  input wire logic host_scl_o,
  input wire logic host_scl_oe,
  input wire logic host_sda_o,
  input wire logic host_sda_oe,
  input wire logic dev_scl_o,
  input wire logic dev_scl_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  // Resolved lines
  input wire logic scl,
  input wire logic sda
);
  // ********************
  // Line tracker
  // ********************
  typedef struct packed {
    logic scl, sda, first, wr, match, idle;
    logic [3:0] cnt;
    logic [6:0] sh;
  } adccs_trk_t;
  adccs_trk_t trk_ff, nxt_trk;
  logic rise, start_seen, stop_seen, ack_slot;
  // Line events as the system clock sees them
  assign rise = scl && !trk_ff.scl;
  assign start_seen = scl && trk_ff.scl && trk_ff.sda && !sda;
  assign stop_seen = scl && trk_ff.scl && !trk_ff.sda && sda;
  assign ack_slot = rise && trk_ff.cnt == 4'h8;
  // Bit count and address capture, restarted by every START
  always_comb begin
    nxt_trk = trk_ff;
    nxt_trk.scl = scl;
    nxt_trk.sda = sda;
    if (start_seen) begin
      nxt_trk.cnt = 4'h0;
      nxt_trk.first = 1'b1;
      nxt_trk.idle = 1'b0;
    end else if (stop_seen) begin
      nxt_trk.idle = 1'b1;
    end else if (ack_slot) begin
      nxt_trk.cnt = 4'h0;
      nxt_trk.first = 1'b0;
    end else if (rise) begin
      nxt_trk.cnt = trk_ff.cnt + 4'h1;
      nxt_trk.sh = {trk_ff.sh[5:0], sda};
      if (trk_ff.first && trk_ff.cnt == 4'h7) begin
        nxt_trk.wr = !sda;
        nxt_trk.match = trk_ff.sh == DEV_ADDR;
      end
    end
  end
  // Lines idle high at reset, so no false edge after release
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      trk_ff <= '{scl: 1'b1, sda: 1'b1, idle: 1'b1, default: '0};
    end else begin
      trk_ff <= nxt_trk;
    end
  end
  // ********************
  // Properties
  // ********************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_open_drain_low: assert property (!dev_scl_o && !dev_sda_o && !host_scl_o && !host_sda_o)
    else $error("pin driver drives high");
  a_addr_silent: assert property (trk_ff.first && trk_ff.cnt < 4'h8 |-> !dev_sda_oe)
    else $error("device drives data during address");
  a_addr_ack: assert property (ack_slot && trk_ff.first |-> sda == !trk_ff.match)
    else $error("address acknowledge wrong");
  a_write_data_ack: assert property (ack_slot && !trk_ff.first && trk_ff.wr && trk_ff.match |-> !sda)
    else $error("written byte not acknowledged");
  a_sda_turn_low: assert property ($changed(dev_sda_oe) |-> !scl)
    else $error("device data changed while clock high");
  a_stretch_in_low: assert property ($rose(dev_scl_oe) |-> !$past(scl))
    else $error("device grabbed clock while high");
  a_stretch_bounded: assert property ($rose(dev_scl_oe) |-> ##[1:1000] !dev_scl_oe)
    else $error("clock stretch too long");
  a_idle_quiet: assert property (trk_ff.idle |-> !dev_sda_oe && !dev_scl_oe)
    else $error("device drives bus while idle");
  c_addr_acked: cover property (ack_slot && trk_ff.first && !sda);
  c_stretch: cover property ($rose(dev_scl_oe));
  c_stop: cover property (stop_seen);
endmodule : adccs_props

/* File: tb_adc_config_scan_control.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_mismatch++; \
  $display("unexpected at %0t: got %0h expected %0h", $time, a, b); end end
module tb_adc_config_scan_control;
  import adccs_pkg::*;
  localparam int REF_WAKE = 20;
  // ********************
  // Signals and instances
  // ********************
  logic clk = 1'b0, rst = 1'b1, ce = 1'b1, cmd_valid = 1'b0, cmd_valid2 = 1'b0, cmd_read = 1'b0;
  logic cmd_wr_setup = 1'b0, rx_ready = 1'b1, c_ready = 1'b0, r_valid = 1'b0, core_busy = 1'b0;
  logic cmd_ready, rx_valid, addr_nack, addr_nack2, busy, busy2, c_valid, c_diff, c_bip, c_ext;
  logic r_ready, powered, ref_rdy, hs_mode2, hs_seen = 1'b0, saw_pow, ext_seen;
  logic [3:0] cmd_count = 4'h0;
  logic [2:0] lat = 3'h0;
  adccs_byte_t cmd_config = 8'h01, cmd_setup = 8'h82, rx_data, cur_cfg = 8'h01, cur_stp = 8'h82, rx_q[$];
  adccs_chan_t c_ch;
  adccs_result_t r_data = 12'h000, res, conv_q[$];
  int seed = 32'h940e93f5, checks = 0, n_mismatch = 0, pw_cnt = 0, first_wait;
  adccs_if lnk();
  adccs_if lnk_mc();
  adccs_host #(.HALF(8)) u_adccs_host (.clk(clk), .rst(rst), .ce(ce), .link(lnk.host), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_read(cmd_read), .cmd_count(cmd_count), .cmd_config(cmd_config),
    .cmd_setup(cmd_setup), .cmd_wr_setup(cmd_wr_setup), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .rx_data(rx_data), .addr_nack(addr_nack), .busy(busy));
  adccs_dev #(.REF_WAKE(REF_WAKE)) u_adccs_dev (.clk(clk), .rst(rst), .ce(ce), .link(lnk.dev),
    .cmd_valid(c_valid), .cmd_ready(c_ready), .cmd_ch(c_ch), .cmd_diff(c_diff), .cmd_bipolar(c_bip),
    .cmd_ext_clk(c_ext), .res_valid(r_valid), .res_ready(r_ready), .res_data(r_data), .powered(powered),
    .ref_ready(ref_rdy), .high_speed_bus_mode());
  // Second bus: a host whose address byte is the high-speed master code
  adccs_host #(.HALF(8), .DEV_ADDR(7'h05)) u_adccs_host_mc (.clk(clk), .rst(rst), .ce(ce), .link(lnk_mc.host),
    .cmd_valid(cmd_valid2), .cmd_ready(), .cmd_read(cmd_read), .cmd_count(cmd_count),
    .cmd_config(cmd_config), .cmd_setup(cmd_setup), .cmd_wr_setup(cmd_wr_setup), .rx_valid(),
    .rx_ready(rx_ready), .rx_data(), .addr_nack(addr_nack2), .busy(busy2));
  adccs_dev #(.REF_WAKE(REF_WAKE)) u_adccs_dev_mc (.clk(clk), .rst(rst), .ce(ce), .link(lnk_mc.dev),
    .cmd_valid(), .cmd_ready(1'b0), .cmd_ch(), .cmd_diff(), .cmd_bipolar(), .cmd_ext_clk(), .res_valid(1'b0),
    .res_ready(), .res_data(12'h000), .powered(), .ref_ready(), .high_speed_bus_mode(hs_mode2));
  adccs_props #(.DEV_ADDR(7'h34)) u_adccs_props (.clk(clk), .rst(rst), .host_scl_o(lnk.host_scl_o),
    .host_scl_oe(lnk.host_scl_oe), .host_sda_o(lnk.host_sda_o), .host_sda_oe(lnk.host_sda_oe),
    .dev_scl_o(lnk.dev_scl_o), .dev_scl_oe(lnk.dev_scl_oe), .dev_sda_o(lnk.dev_sda_o),
    .dev_sda_oe(lnk.dev_sda_oe), .scl(lnk.scl), .sda(lnk.sda));
  // Clock
  initial forever #10 clk = ~clk;
  // Analog core stand-in and receive side; one conversion in flight, random stalls
  always @(posedge clk) begin
    ce <= 3'($random(seed)) != 3'h0; // Random freezes; handshakes count only while ce is high
    if (ce) begin
      rx_ready <= 1'($random(seed));
      if (rx_valid && rx_ready) rx_q.push_back(rx_data);
      if (hs_mode2) hs_seen <= 1'b1;
      if (powered) saw_pow <= 1'b1;
      pw_cnt <= powered ? pw_cnt + 1 : 0;
      if (!core_busy) begin
        c_ready <= 1'($random(seed));
        if (c_valid && c_ready) begin
          `CHK(ref_rdy, 1'b1)
          core_busy <= 1'b1;
          c_ready <= 1'b0;
          lat <= 3'($random(seed));
          res = {c_ch, c_diff, c_bip, 8'($random(seed))};
          r_data <= res;
          conv_q.push_back(res);
          ext_seen <= c_ext;
          if (first_wait < 0) first_wait <= pw_cnt;
        end
      end else if (lat != 3'h0) begin
        lat <= lat - 3'h1;
      end else if (!r_valid) begin
        r_valid <= 1'b1;
      end else if (r_ready) begin
        r_valid <= 1'b0;
        core_busy <= 1'b0;
      end
    end
  end
  // ********************
  // Expectations
  // ********************
  function automatic int exp_n(input adccs_byte_t cfg, input adccs_byte_t stp);
    case (cfg[6:5])
      2'b01: return 8;
      2'b11: return 1;
      default: return int'(cfg[2:1]) + 1 - int'(cfg[2:1] == 2'h3 && stp[5]);
    endcase
  endfunction : exp_n
  function automatic adccs_chan_t exp_ch(input adccs_byte_t cfg, input int i);
    return cfg[5] ? cfg[2:1] : 2'(i);
  endfunction : exp_ch
  // One host command; the host sends config before setup
  task automatic run_cmd(input logic rd, input logic [3:0] cnt, input adccs_byte_t cfg, input adccs_byte_t stp,
                         input logic ws);
    int n;
    logic exact;
    adccs_byte_t hi;
    conv_q.delete();
    rx_q.delete();
    first_wait = -1;
    saw_pow = 1'b0;
    @(posedge clk);
    {cmd_read, cmd_count, cmd_config, cmd_setup, cmd_wr_setup, cmd_valid} <= {rd, cnt, cfg, stp, ws, 1'b1};
    @(negedge clk);
    while (!busy) @(negedge clk);
    @(posedge clk);
    cmd_valid <= 1'b0;
    repeat (4) @(negedge clk);
    `CHK(cmd_ready, 1'b0)
    while (busy) @(negedge clk);
    repeat (40) @(negedge clk);
    `CHK(addr_nack, 1'b0)
    if (!rd) begin
      cur_cfg = (ws && !stp[1]) ? 8'h01 : {1'b0, cfg[6:0]};
      if (ws) cur_stp = {1'b1, stp[6:0]};
    end else begin
      n = exp_n(cur_cfg, cur_stp);
      exact = cur_cfg[6:5] != 2'b10 && !cur_stp[3];
      `CHK(rx_q.size(), int'(cnt))
      if (exact) `CHK(conv_q.size(), n)
      for (int i = 0; i < rx_q.size(); i++) begin
        hi = {1'b1, exp_ch(cur_cfg, (i / 2) % n), 1'b1, exp_ch(cur_cfg, (i / 2) % n), !cur_cfg[0],
              cur_stp[2] && !cur_cfg[0]};
        if (i % 2 == 0) `CHK(rx_q[i], hi)
        else if (exact) `CHK(rx_q[i], conv_q[(i / 2) % n][7:0])
      end
      if (conv_q.size() > 0) `CHK(ext_seen, cur_stp[3])
      if (cur_cfg[6:5] != 2'b10) `CHK(powered, 1'b0)
      `CHK(saw_pow, 1'b1)
      if (cur_stp[6] && !cur_stp[4]) `CHK(first_wait >= REF_WAKE, 1'b1)
    end
    $display("test done: read %0b count %0d config %h", rd, cnt, cur_cfg);
  endtask : run_cmd
  task automatic wr_rd(input adccs_byte_t cfg, input adccs_byte_t stp, input logic [3:0] cnt);
    run_cmd(1'b0, 4'h0, cfg, stp, 1'b1);
    run_cmd(1'b1, cnt, 8'h00, 8'h00, 1'b0);
  endtask : wr_rd
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop
  // ********************
  // Test sequence
  // ********************
  initial begin
    logic [1:0] sc;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    run_cmd(1'b1, 4'h4, 8'h00, 8'h00, 1'b0); // Power-up config, read wraps
    wr_rd(8'h6B, 8'h80, 4'h2); // Setup reset clears the config just written
    wr_rd(8'h07, 8'hA2, 4'h6); // Input 3 taken as reference
    wr_rd(8'h25, 8'h82, 4'hF); // Eight repeats
    wr_rd(8'h66, 8'hC6, 4'h2); // Differential, bipolar, internal reference wake
    wr_rd(8'h61, 8'h8A, 4'h2); // Conversion clock from the bus
    repeat (5) begin
      sc = 2'($random(seed));
      if (sc == 2'b10) sc = 2'b11;
      wr_rd({1'($random(seed)), sc, 2'b00, 2'($random(seed)), sc == 2'b00 || 1'($random(seed))},
            {1'b1, 3'($random(seed)), 1'b0, 1'($random(seed)), 2'b10}, 4'($random(seed)) | 4'h1);
    end
    // Master code on the second bus is refused and undone by STOP
    @(posedge clk);
    cmd_valid2 <= 1'b1;
    @(negedge clk);
    while (!busy2) @(negedge clk);
    @(posedge clk);
    cmd_valid2 <= 1'b0;
    repeat (4) @(negedge clk);
    while (busy2) @(negedge clk);
    repeat (20) @(negedge clk);
    `CHK(addr_nack2, 1'b1)
    `CHK(hs_seen, 1'b1)
    `CHK(hs_mode2, 1'b0)
    $display("test done: master code");
    wr_rd(8'h45, 8'h82, 4'hC); // Monitor mode keeps scanning, last since it never stops
    report_and_stop();
  end
  // Watchdog
  initial begin
    repeat (90000) @(posedge clk);
    n_mismatch++;
    $display("unexpected at %0t: watchdog expired", $time);
    report_and_stop();
  end
endmodule : tb_adc_config_scan_control
